// ==== dv/low_power_tia_switch_control_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module low_power_tia_switch_control_regs_test
    import lp_amp_regs_pkg::*;
;
    typedef struct packed {
        logic        isPin;
        logic [38:0] value;
    } note_s;

    // clock, reset and bus drive
    logic                          clock;
    logic                          sys_rst;
    logic                          hsel;
    logic [31:0]                   haddr;
    logic [1:0]                    htrans;
    logic                          hwrite;
    logic [2:0]                    hsize;
    logic [31:0]                   hwdata;
    logic                          hready;
    logic [31:0]                   hrdata;
    logic                          hreadyout;
    logic                          hresp;
    logic [SWITCH_LOW_COUNT-1:0]   loopSwitch;
    logic                          loopSwitch15;
    logic [FILTER_WIDTH-1:0]       filterResistorSelect;
    logic                          lowpassFilterPinConnect;
    logic                          filterBypass;
    logic [FILTER_TAP_COUNT-1:0]   filterTap;
    logic [CONTROL_OTHER_WIDTH-1:0] controlOther;
    // bench state
    logic [38:0]                   pinState;
    logic [38:0]                   got;
    logic                          pinStrobe;
    logic                          rdPhase;
    logic [31:0]                   seed;
    logic [31:0]                   swModel;
    logic [31:0]                   ctlModel;
    logic [31:0]                   d;
    note_s                         notes[$];
    note_s                         n;
    int                            mismatches;
    int                            checked;

    ////////////////////////////////////////////////////////////////////////////////
    // single slave, so its ready is the bus ready
    assign hready   = hreadyout;
    assign pinState = {loopSwitch15, loopSwitch, filterResistorSelect, lowpassFilterPinConnect,
                       filterBypass, filterTap, controlOther};

    lp_amp_switch_control_regs u_lp_amp_switch_control_regs (
        .clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .loopSwitch(loopSwitch), .loopSwitch15(loopSwitch15),
        .filterResistorSelect(filterResistorSelect), .lowpassFilterPinConnect(lowpassFilterPinConnect),
        .filterBypass(filterBypass), .filterTap(filterTap), .controlOther(controlOther)
    );

    // 40 MHz clock
    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // pin image worked out from the two register values
    function automatic logic [38:0] expect_pins(input logic [31:0] sw, input logic [31:0] ctl);
        logic [2:0] code;
        logic [5:0] tap;
        code = ctl[15:13];
        tap  = (code >= 3'h2) ? (6'h01 << (code - 3'h2)) : 6'h00;
        return {sw[15], sw[13:0], code, code != 3'h0, code == 3'h1, tap, ctl[12:0]};
    endfunction

    // one ahb single transfer; waits on ready, never on a fixed count
    // only the watchdog ends a wait that never sees ready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] dat);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do begin
            @(posedge clock);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        if (w) begin
            hwdata <= dat;
        end
        do begin
            @(posedge clock);
        end while (hready !== 1'b1);
    endtask

    // reserved bits are masked in the model, unmapped writes dropped
    task automatic wr(input logic [31:0] a, input logic [31:0] dat);
        xfer(1'b1, a, dat);
        if (a == SWITCH_CONFIG_ADDR) swModel = dat & 32'h0000BFFF;
        if (a == CONTROL_ADDR) ctlModel = dat & 32'h0000FFFF;
    endtask

    task automatic rd(input logic [31:0] a);
        logic [31:0] e;
        e = (a == SWITCH_CONFIG_ADDR) ? swModel : (a == CONTROL_ADDR) ? ctlModel : 32'h00000000;
        // data phase must also show ready high and an OKAY response
        notes.push_back('{1'b0, {5'h00, 1'b1, HRESP_OKAY, e}});
        xfer(1'b0, a, 32'h00000000);
    endtask

    // decode outputs lag the register by one edge, so let two pass first
    task automatic pinchk();
        notes.push_back('{1'b1, expect_pins(swModel, ctlModel)});
        repeat (2) @(posedge clock);
        pinStrobe <= 1'b1;
        @(posedge clock);
        pinStrobe <= 1'b0;
    endtask

    task automatic end_test(input string name);
        $display("test %s done: checked=%0d mismatches=%0d", name, checked, mismatches);
    endtask

    task automatic give_verdict();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: a read data phase or a pin strobe consumes the oldest note
    always @(posedge clock) rdPhase <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && !sys_rst;

    always @(negedge clock) begin
        if (rdPhase || pinStrobe) begin
            checked++;
            if (notes.size() == 0) begin
                mismatches++;
                $display("Error at %0t: got 0x%h expected 0x%h, no note queued", $time, pinState, 39'h0);
            end else begin
                n   = notes.pop_front();
                got = n.isPin ? pinState : {5'h00, hreadyout, hresp, hrdata};
                if (got !== n.value) begin
                    mismatches++;
                    $display("Error at %0t: got 0x%h expected 0x%h", $time, got, n.value);
                end
            end
        end
    end

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        pinStrobe = 1'b0;
        seed = 32'h7E133B9A;
        mismatches = 0;
        checked = 0;
        swModel = SWITCH_CONFIG_RESET;
        ctlModel = CONTROL_RESET;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rd(SWITCH_CONFIG_ADDR);
        rd(CONTROL_ADDR);
        pinchk();
        end_test("reset values");
        // every filter code, with random other and reserved bits
        for (int c = 0; c < 8; c++) begin
            seed = next_rand(seed);
            d = seed;
            d[15:13] = c[2:0];
            wr(CONTROL_ADDR, d);
            rd(CONTROL_ADDR);
            pinchk();
        end
        end_test("filter codes");
        // every switch alone, then all ones and random words
        for (int b = 0; b < 16; b++) begin
            wr(SWITCH_CONFIG_ADDR, 32'h00000001 << b);
            pinchk();
        end
        wr(SWITCH_CONFIG_ADDR, 32'hFFFFFFFF);
        rd(SWITCH_CONFIG_ADDR);
        for (int i = 0; i < 6; i++) begin
            seed = next_rand(seed);
            wr(SWITCH_CONFIG_ADDR, seed);
            rd(SWITCH_CONFIG_ADDR);
            pinchk();
        end
        end_test("switches");
        // unmapped places in the gap between the two registers and just below the switch register
        seed = next_rand(seed);
        wr(32'h000020E8, seed);
        wr(32'h000020E0, ~seed);
        rd(32'h000020E8);
        rd(SWITCH_CONFIG_ADDR);
        rd(CONTROL_ADDR);
        pinchk();
        end_test("unmapped");
        // second reset in mid-run restores both registers
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        swModel = SWITCH_CONFIG_RESET;
        ctlModel = CONTROL_RESET;
        @(posedge clock);
        rd(SWITCH_CONFIG_ADDR);
        rd(CONTROL_ADDR);
        pinchk();
        end_test("second reset");
        give_verdict();
    end
endmodule
`default_nettype wire

// ==== rtl/filter_ctl_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface filter_ctl_if;
    import lp_amp_regs_pkg::*;
    logic [2:0] code;
    logic       outputConnect;
    logic       bypass;
    logic [5:0] tapSelect;
    modport ctl (output code, input outputConnect, input bypass, input tapSelect);
    modport dec (input code, output outputConnect, output bypass, output tapSelect);
endinterface
`default_nettype wire

// ==== rtl/filter_select_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module filter_select_decode
    import lp_amp_regs_pkg::*;
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   sys_rst,
    // code in, registered decode out
    filter_ctl_if.dec   filt
);
    logic       connect_reg, connect_next;
    logic       bypass_reg, bypass_next;
    logic [5:0] tap_reg, tap_next;

    // decode the filter code into switch controls
    always_comb begin
        connect_next = 1'b1;
        bypass_next  = 1'b0;
        tap_next     = TAP_NONE;
        case (filter_code_e'(filt.code))
            FILTER_DISCONNECT: connect_next = 1'b0;
            FILTER_BYPASS:     bypass_next  = 1'b1;
            FILTER_20K:        tap_next = TAP_20K;
            FILTER_100K:       tap_next = TAP_100K;
            FILTER_200K:       tap_next = TAP_200K;
            FILTER_400K:       tap_next = TAP_400K;
            FILTER_600K:       tap_next = TAP_600K;
            FILTER_1M:         tap_next = TAP_1M;
            default:           connect_next = 1'b0;
        endcase
    end

    // registered so no decode glitch reaches the analog switches
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            connect_reg <= 1'b0;
            bypass_reg  <= 1'b0;
            tap_reg     <= TAP_NONE;
        end else begin
            connect_reg <= connect_next;
            bypass_reg  <= bypass_next;
            tap_reg     <= tap_next;
        end
    end

    assign filt.outputConnect = connect_reg;
    assign filt.bypass        = bypass_reg;
    assign filt.tapSelect     = tap_reg;
endmodule
`default_nettype wire

// ==== rtl/lp_amp_regs_pkg.sv ====
package lp_amp_regs_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] SWITCH_CONFIG_ADDR = 32'h0000_20E4;
    localparam logic [31:0] CONTROL_ADDR       = 32'h0000_20EC;

    // reset values
    localparam logic [31:0] SWITCH_CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET       = 32'h0000_0003;

    // switch register layout
    localparam int          SWITCH_LOW_COUNT = 14;
    localparam int          SWITCH_HIGH_BIT  = 15;

    // control register layout
    localparam int          FILTER_LSB       = 13;
    localparam int          FILTER_WIDTH     = 3;
    localparam int          CONTROL_OTHER_WIDTH = 13;
    localparam int          FILTER_TAP_COUNT = 6;

    // filter resistor codes
    typedef enum logic [2:0] {
        FILTER_DISCONNECT = 3'h0,
        FILTER_BYPASS     = 3'h1,
        FILTER_20K        = 3'h2,
        FILTER_100K       = 3'h3,
        FILTER_200K       = 3'h4,
        FILTER_400K       = 3'h5,
        FILTER_600K       = 3'h6,
        FILTER_1M         = 3'h7
    } filter_code_e;

    // one-hot tap positions: 20k,100k,200k,400k,600k,1M
    localparam logic [5:0]  TAP_NONE = 6'h00;
    localparam logic [5:0]  TAP_20K  = 6'h01;
    localparam logic [5:0]  TAP_100K = 6'h02;
    localparam logic [5:0]  TAP_200K = 6'h04;
    localparam logic [5:0]  TAP_400K = 6'h08;
    localparam logic [5:0]  TAP_600K = 6'h10;
    localparam logic [5:0]  TAP_1M   = 6'h20;

    // ahb encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// ==== rtl/lp_amp_switch_control_regs.sv ====
// Operation
// - switch register at 0x20E4, resets all open
// - bit 15 drives loop_switch_15, read/write
// - bits 13..0 drive loop switches 0..13
// - control register at 0x20EC, resets to 0x3
// - bits 15..13 filter resistor code, read/write
// - code 0 disconnects, code 1 bypasses
// - codes 2..6 select increasing resistors
// - code 7 selects 1 Mohm, lowest cutoff
`timescale 1ns/1ps
`default_nettype none
module lp_amp_switch_control_regs
    import lp_amp_regs_pkg::*;
(
    // clock and reset
    input  wire logic                           clock,
    input  wire logic                           sys_rst,
    // ahb-lite slave
    input  wire logic                           hsel,
    input  wire logic [31:0]                    haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic [31:0]                         hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    // loop switch controls
    output logic [SWITCH_LOW_COUNT-1:0]         loopSwitch,
    output logic                                loopSwitch15,
    // low-pass filter controls
    output logic [FILTER_WIDTH-1:0]             filterResistorSelect,
    output logic                                lowpassFilterPinConnect,
    output logic                                filterBypass,
    output logic [FILTER_TAP_COUNT-1:0]         filterTap,
    // remaining control bits for the load and gain banks
    output logic [CONTROL_OTHER_WIDTH-1:0]      controlOther
);

    ////////////////////////////////////////////////////////////////////////////////
    // bus address phase

    logic        wrSwitch_reg, wrSwitch_next;
    logic        wrControl_reg, wrControl_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        readyOut_reg;
    logic        resp_reg;
    logic        addrValid;
    logic [31:0] switchWord;
    logic [31:0] controlWord;

    // hsize is ignored: only whole-word accesses are supported
    assign addrValid = hsel && hready && (htrans == HTRANS_NONSEQ);

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    logic [SWITCH_LOW_COUNT-1:0]    lowSw_reg, lowSw_next;
    logic                           sw15_reg, sw15_next;
    logic [FILTER_WIDTH-1:0]        filt_reg, filt_next;
    logic [CONTROL_OTHER_WIDTH-1:0] other_reg, other_next;

    // data phase writes land at the end of the data phase
    always_comb begin
        lowSw_next = lowSw_reg;
        sw15_next  = sw15_reg;
        filt_next  = filt_reg;
        other_next = other_reg;
        if (wrSwitch_reg) begin
            lowSw_next = hwdata[SWITCH_LOW_COUNT-1:0];
            sw15_next  = hwdata[SWITCH_HIGH_BIT];
        end
        if (wrControl_reg) begin
            filt_next  = hwdata[FILTER_LSB +: FILTER_WIDTH];
            other_next = hwdata[CONTROL_OTHER_WIDTH-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lowSw_reg <= SWITCH_CONFIG_RESET[SWITCH_LOW_COUNT-1:0];
            sw15_reg  <= SWITCH_CONFIG_RESET[SWITCH_HIGH_BIT];
            filt_reg  <= CONTROL_RESET[FILTER_LSB +: FILTER_WIDTH];
            other_reg <= CONTROL_RESET[CONTROL_OTHER_WIDTH-1:0];
        end else begin
            lowSw_reg <= lowSw_next;
            sw15_reg  <= sw15_next;
            filt_reg  <= filt_next;
            other_reg <= other_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    // read words built from next values so a read right after a write sees it
    always_comb begin
        switchWord = 32'h0000_0000;
        controlWord = 32'h0000_0000;
        switchWord[SWITCH_LOW_COUNT-1:0]   = lowSw_next;
        switchWord[SWITCH_HIGH_BIT]        = sw15_next;
        controlWord[FILTER_LSB +: FILTER_WIDTH]   = filt_next;
        controlWord[CONTROL_OTHER_WIDTH-1:0]      = other_next;
    end

    // address decode; unmapped addresses read zero and drop writes
    always_comb begin
        wrSwitch_next  = 1'b0;
        wrControl_next = 1'b0;
        rdata_next     = rdata_reg;
        if (addrValid) begin
            wrSwitch_next  = hwrite && (haddr == SWITCH_CONFIG_ADDR);
            wrControl_next = hwrite && (haddr == CONTROL_ADDR);
            if (!hwrite) begin
                if (haddr == SWITCH_CONFIG_ADDR) begin
                    rdata_next = switchWord;
                end else if (haddr == CONTROL_ADDR) begin
                    rdata_next = controlWord;
                end else begin
                    rdata_next = 32'h0000_0000;
                end
            end
        end
    end

    // zero wait state slave, always OKAY
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wrSwitch_reg  <= 1'b0;
            wrControl_reg <= 1'b0;
            rdata_reg     <= 32'h0000_0000;
            readyOut_reg  <= 1'b1;
            resp_reg      <= HRESP_OKAY;
        end else begin
            wrSwitch_reg  <= wrSwitch_next;
            wrControl_reg <= wrControl_next;
            rdata_reg     <= rdata_next;
            readyOut_reg  <= 1'b1;
            resp_reg      <= HRESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // filter decode

    filter_ctl_if filt ();

    assign filt.code = filt_reg;

    filter_select_decode u_decode (
        .clock   (clock),
        .sys_rst (sys_rst),
        .filt    (filt.dec)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a flip-flop

    assign hrdata                  = rdata_reg;
    assign hreadyout               = readyOut_reg;
    assign hresp                   = resp_reg;
    assign loopSwitch              = lowSw_reg;
    assign loopSwitch15            = sw15_reg;
    assign filterResistorSelect    = filt_reg;
    assign controlOther            = other_reg;
    assign lowpassFilterPinConnect = filt.outputConnect;
    assign filterBypass            = filt.bypass;
    assign filterTap               = filt.tapSelect;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    property p_switch_reset;
        @(posedge clock) $fell(sys_rst) |-> (loopSwitch == '0) && !loopSwitch15;
    endproperty
    a_switch_reset: assert property (p_switch_reset) else $error("switches not open after reset");

    property p_sw15_write;
        @(posedge clock) disable iff (sys_rst)
        wrSwitch_reg |=> (loopSwitch15 == $past(hwdata[SWITCH_HIGH_BIT]));
    endproperty
    a_sw15_write: assert property (p_sw15_write) else $error("switch 15 did not take written bit");

    property p_low_write;
        @(posedge clock) disable iff (sys_rst)
        wrSwitch_reg |=> (loopSwitch == $past(hwdata[SWITCH_LOW_COUNT-1:0]));
    endproperty
    a_low_write: assert property (p_low_write) else $error("low switches did not take written bits");

    property p_control_reset;
        @(posedge clock) $fell(sys_rst) |-> (controlOther == CONTROL_RESET[CONTROL_OTHER_WIDTH-1:0])
            && (filterResistorSelect == FILTER_DISCONNECT);
    endproperty
    a_control_reset: assert property (p_control_reset) else $error("control reset value wrong");

    property p_filter_readback;
        @(posedge clock) disable iff (sys_rst)
        (addrValid && hwrite && (haddr == CONTROL_ADDR)) ##1 1'b1 ##1
            (addrValid && !hwrite && (haddr == CONTROL_ADDR))
        |=> (hrdata[FILTER_LSB +: FILTER_WIDTH] == $past(hwdata[FILTER_LSB +: FILTER_WIDTH], 2));
    endproperty
    a_filter_readback: assert property (p_filter_readback) else $error("filter field read back wrong");

    property p_code_zero;
        @(posedge clock) disable iff (sys_rst)
        (filterResistorSelect == FILTER_DISCONNECT) ##1 !$past(sys_rst)
        |-> !lowpassFilterPinConnect && !filterBypass && (filterTap == TAP_NONE);
    endproperty
    a_code_zero: assert property (p_code_zero) else $error("code 0 left filter connected");

    property p_tap_onehot;
        @(posedge clock) disable iff (sys_rst)
        (filterResistorSelect >= FILTER_20K) |=> (filterTap == (6'h01 << ($past(filterResistorSelect) - 3'h2)));
    endproperty
    a_tap_onehot: assert property (p_tap_onehot) else $error("resistor tap order wrong");

    property p_code_max;
        @(posedge clock) disable iff (sys_rst)
        (filterResistorSelect == FILTER_1M) |=> filterTap[FILTER_TAP_COUNT-1] && lowpassFilterPinConnect;
    endproperty
    a_code_max: assert property (p_code_max) else $error("code 7 did not select top resistor");

    property p_reserved_zero;
        @(posedge clock) disable iff (sys_rst)
        (addrValid && !hwrite && (haddr == SWITCH_CONFIG_ADDR)) |=> (hrdata[31:16] == 16'h0000) && !hrdata[14];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved switch bits not zero");

endmodule
`default_nettype wire
